// file: inc/afz_pkg.sv
// package for the arc-flash zone trip logic: widths, defaults, enumerations
// assumes a single program-cycle clock domain shared by all users
package afz_pkg;
	localparam int ZONES = 4;
	localparam int CHANS = 4;
	localparam int CUR_W = 16;
	localparam int THR_W = 13;
	localparam logic [THR_W-1:0] PH_THR_RST = 13'h0078;
	localparam logic [THR_W-1:0] RES_THR_RST = 13'h0078;
	localparam logic [3:0] ZONE_EN_RST = 4'h0;
	localparam logic [3:0] SAMPLE_MIN_RST = 4'h1;
	localparam logic [3:0] WINDOW_LEN_RST = 4'h5;
	localparam int WINDOW_MS = 5;
	localparam int SAMPLES_PER_WINDOW = 5;
	localparam int BLOCK_LEAD_MS = 5;
	localparam int CLK_MHZ = 250;
	typedef enum logic [1:0] {
		AFZ_RES_NONE = 2'b00,
		AFZ_RES_FIRST = 2'b01,
		AFZ_RES_SECOND = 2'b10
	} afz_res_sel_t;
	typedef enum logic [1:0] {
		AFZ_DI_OFF = 2'b00,
		AFZ_DI_DIRECT = 2'b01,
		AFZ_DI_QUAL = 2'b10
	} afz_di_mode_t;
	typedef enum logic [2:0] {
		AFZ_MODE_ON = 3'b000,
		AFZ_MODE_BLOCKED = 3'b001,
		AFZ_MODE_TEST = 3'b010,
		AFZ_MODE_TEST_BLOCKED = 3'b011,
		AFZ_MODE_OFF = 3'b100
	} afz_mode_t;
endpackage : afz_pkg

// file: inc/afz_cur_if.sv
// interface carrying one current-condition decision between modules
// assumes the clocks of both ends are the same program-cycle clock
`timescale 1ns/1ps
interface afz_cur_if;
	logic active;
	logic blocked;
	modport src (output active, output blocked);
	modport dst (input active, input blocked);
endinterface : afz_cur_if

// file: hdl/afz_cur_det.sv
// current condition detector: counts samples over threshold per window
// assumes sample_valid marks one new sample per program cycle
`timescale 1ns/1ps
module afz_cur_det
	import afz_pkg::*;
(
	input wire logic clk,
	input wire logic srst,
	input wire logic sample_valid,
	input wire logic over,
	input wire logic enable,
	input wire logic blk,
	input wire logic [3:0] need,
	afz_cur_if.src cond
);
	import afz_pkg::*;
	logic [3:0] cnt;
	logic [3:0] pos;
	logic act;
	wire last_pos = (pos == WINDOW_LEN_RST - 4'h1);
	wire [3:0] next_cnt = over ? cnt + 4'h1 : cnt;
	always_ff @(posedge clk) begin
		if (srst) begin
			cnt <= 4'h0;
			pos <= 4'h0;
			act <= 1'b0;
		end else if (sample_valid) begin
			// window closes: decide on the count, including this sample
			if (last_pos) begin
				act <= enable && (next_cnt >= need);
				cnt <= 4'h0;
				pos <= 4'h0;
			end else begin
				cnt <= next_cnt;
				pos <= pos + 4'h1;
			end
		end
	end
	// enable gates the outputs too, so a deselected source drops at once
	assign cond.active = act && enable && !blk;
	assign cond.blocked = act && enable && blk;
endmodule : afz_cur_det

// file: hdl/afz_zone_trip.sv
// arc-flash zone decision logic for four zones and four sensor channels
// assumes all inputs except the sensor, digital input, blocking and unit fault pins are clk-synchronous
`timescale 1ns/1ps
module afz_zone_trip
	import afz_pkg::*;
(
	input wire logic clk,
	input wire logic srst,
	input wire logic cycle_start,
	input wire logic sample_valid,
	input wire logic [CUR_W-1:0] phase_a_current,
	input wire logic [CUR_W-1:0] phase_b_current,
	input wire logic [CUR_W-1:0] phase_c_current,
	input wire logic [CUR_W-1:0] residual_input_first,
	input wire logic [CUR_W-1:0] residual_input_second,
	input wire logic [THR_W-1:0] ph_thr,
	input wire logic [THR_W-1:0] res_thr,
	input wire logic ph_thr_load,
	input wire logic res_thr_load,
	input wire logic [1:0] res_sel,
	input wire logic [3:0] sample_need,
	input wire logic [ZONES-1:0] zone_en,
	input wire logic [ZONES-1:0] zone_ph_en,
	input wire logic [ZONES-1:0] zone_res_en,
	input wire logic [ZONES*CHANS-1:0] zone_light_en,
	input wire logic [ZONES*CHANS-1:0] zone_pres_en,
	input wire logic [ZONES*2-1:0] zone_di_mode,
	input wire logic [2:0] mode_set,
	input wire logic [CHANS-1:0] light_pin,
	input wire logic [CHANS-1:0] pres_pin,
	input wire logic di_pin,
	input wire logic block_pin,
	input wire logic io_fault_pin,
	input wire logic [CHANS*2-1:0] sensors_cfg,
	input wire logic [CHANS*2-1:0] sensors_found,
	output logic [ZONES-1:0] zone_trip,
	output logic [ZONES-1:0] zone_blocked,
	output logic phase_overcurrent_pickup,
	output logic ph_curr_blocked,
	output logic res_curr_start,
	output logic res_curr_blocked,
	output logic [CHANS-1:0] chan_light,
	output logic [CHANS-1:0] chan_pres,
	output logic di_status,
	output logic [CHANS-1:0] sensor_fault,
	output logic io_fault,
	output logic [2:0] mode_status
);
	import afz_pkg::*;

	function automatic logic over_thr(input logic [CUR_W-1:0] cur, input logic [THR_W-1:0] thr);
		over_thr = cur > {{(CUR_W-THR_W){1'b0}}, thr};
	endfunction : over_thr

	// pin inputs: two-stage synchronisers, first stage read only by the second
	logic [CHANS*2+2:0] sync1;
	logic [CHANS*2+2:0] sync2;
	always_ff @(posedge clk) begin
		if (srst) begin
			sync1 <= '0;
			sync2 <= '0;
		end else begin
			sync1 <= {io_fault_pin, block_pin, di_pin, pres_pin, light_pin};
			sync2 <= sync1;
		end
	end
	wire [CHANS-1:0] light_s = sync2[CHANS-1:0];
	wire [CHANS-1:0] pres_s = sync2[2*CHANS-1:CHANS];
	wire di_s = sync2[2*CHANS];
	wire block_s = sync2[2*CHANS+1];
	wire io_fault_s = sync2[2*CHANS+2];

	// thresholds held internally so reset gives the 1.2 p.u. defaults
	logic [THR_W-1:0] ph_thr_q;
	logic [THR_W-1:0] res_thr_q;
	logic block_q;
	always_ff @(posedge clk) begin
		if (srst) begin
			ph_thr_q <= PH_THR_RST;
			res_thr_q <= RES_THR_RST;
		end else begin
			// live reload, no restart of the detectors
			if (ph_thr_load)
				ph_thr_q <= ph_thr;
			if (res_thr_load)
				res_thr_q <= res_thr;
		end
	end
	always_ff @(posedge clk) begin
		if (srst)
			block_q <= 1'b0;
		else if (cycle_start)
			block_q <= block_s;
	end

	// operating mode; unknown codes read back as off
	wire [2:0] mode_v = (mode_set > AFZ_MODE_OFF) ? AFZ_MODE_OFF : mode_set;
	wire mode_blocks = (mode_v == AFZ_MODE_BLOCKED) || (mode_v == AFZ_MODE_TEST_BLOCKED);
	wire mode_off = (mode_v == AFZ_MODE_OFF);
	wire blk_eff = block_q || mode_blocks;

	wire ph_over = over_thr(phase_a_current, ph_thr_q) ||
		over_thr(phase_b_current, ph_thr_q) ||
		over_thr(phase_c_current, ph_thr_q);
	wire [CUR_W-1:0] res_cur = (res_sel == AFZ_RES_SECOND) ? residual_input_second
		: residual_input_first;
	wire res_on = (res_sel == AFZ_RES_FIRST) || (res_sel == AFZ_RES_SECOND);
	wire res_over = res_on && over_thr(res_cur, res_thr_q);

	afz_cur_if ph_cond ();
	afz_cur_if res_cond ();
	afz_cur_det u_ph (
		.clk(clk),
		.srst(srst),
		.sample_valid(sample_valid),
		.over(ph_over),
		.enable(1'b1),
		.blk(blk_eff),
		.need(sample_need),
		.cond(ph_cond.src)
	);
	afz_cur_det u_res (
		.clk(clk),
		.srst(srst),
		.sample_valid(sample_valid),
		.over(res_over),
		.enable(res_on),
		.blk(blk_eff),
		.need(sample_need),
		.cond(res_cond.src)
	);
	wire ph_raw = ph_cond.active || ph_cond.blocked;
	wire res_raw = res_cond.active || res_cond.blocked;

	// per-zone pick-up
	logic [ZONES-1:0] pickup;
	always_comb begin
		for (int z = 0; z < ZONES; z++) begin
			logic sens;
			logic qual;
			logic di_hit;
			sens = |(light_s & zone_light_en[z*CHANS +: CHANS]) |
				|(pres_s & zone_pres_en[z*CHANS +: CHANS]);
			qual = (!zone_ph_en[z] || ph_raw) && (!zone_res_en[z] || res_raw);
			di_hit = 1'b0;
			if (zone_di_mode[z*2 +: 2] == AFZ_DI_DIRECT)
				di_hit = di_s;
			if (zone_di_mode[z*2 +: 2] == AFZ_DI_QUAL)
				sens = sens && di_s;
			pickup[z] = zone_en[z] && !mode_off && ((sens && qual) || di_hit);
		end
	end

	logic [ZONES-1:0] next_trip;
	logic [ZONES-1:0] next_blocked;
	assign next_trip = pickup & {ZONES{!blk_eff}};
	assign next_blocked = pickup & {ZONES{blk_eff}};

	// sensor count mismatch per channel
	logic [CHANS-1:0] next_fault;
	always_comb begin
		for (int c = 0; c < CHANS; c++)
			next_fault[c] = sensors_cfg[c*2 +: 2] != sensors_found[c*2 +: 2];
	end

	// condition status: one register stage after the pick-up decision
	always_ff @(posedge clk) begin
		if (srst) begin
			zone_trip <= '0;
			zone_blocked <= '0;
		end else begin
			zone_trip <= next_trip;
			zone_blocked <= next_blocked;
		end
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			phase_overcurrent_pickup <= 1'b0;
			ph_curr_blocked <= 1'b0;
			res_curr_start <= 1'b0;
			res_curr_blocked <= 1'b0;
		end else begin
			phase_overcurrent_pickup <= ph_cond.active;
			ph_curr_blocked <= ph_cond.blocked;
			res_curr_start <= res_cond.active;
			res_curr_blocked <= res_cond.blocked;
		end
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			chan_light <= '0;
			chan_pres <= '0;
			di_status <= 1'b0;
			sensor_fault <= '0;
			io_fault <= 1'b0;
		end else begin
			chan_light <= light_s;
			chan_pres <= pres_s;
			di_status <= di_s;
			sensor_fault <= next_fault;
			io_fault <= io_fault_s;
		end
	end

	always_ff @(posedge clk) begin
		if (srst)
			mode_status <= AFZ_MODE_ON;
		else
			mode_status <= mode_v;
	end

	// pin-path checks need three clean edges since the last reset
	logic [2:0] rst_hist;
	always_ff @(posedge clk)
		rst_hist <= {rst_hist[1:0], srst};
	wire pins_settled = (rst_hist == 3'h0);

	trip_excl_a: assert property (@(posedge clk) disable iff (srst)
		!(|(zone_trip & zone_blocked)))
		else $error("zone trip and blocked together");

	trip_cause_a: assert property (@(posedge clk) disable iff (srst)
		(pickup != '0 && !blk_eff) |=> (zone_trip == $past(pickup)))
		else $error("trip missing after unblocked pick-up");

	blocked_cause_a: assert property (@(posedge clk) disable iff (srst)
		(pickup != '0 && blk_eff) |=> (zone_blocked == $past(pickup) && zone_trip == '0))
		else $error("blocked indication wrong");

	zone_off_a: assert property (@(posedge clk) disable iff (srst)
		(zone_en == '0) |=> (zone_trip == '0 && zone_blocked == '0))
		else $error("disabled zone reported");

	mode_off_a: assert property (@(posedge clk) disable iff (srst)
		(mode_set == AFZ_MODE_OFF) |=> (zone_trip == '0 && zone_blocked == '0))
		else $error("zone reported while function off");

	mode_block_a: assert property (@(posedge clk) disable iff (srst)
		(mode_set == AFZ_MODE_BLOCKED || mode_set == AFZ_MODE_TEST_BLOCKED)
			|=> (zone_trip == '0))
		else $error("trip while function blocked");

	block_hold_a: assert property (@(posedge clk) disable iff (srst)
		!cycle_start |=> $stable(block_q))
		else $error("block sample moved mid-cycle");

	block_take_a: assert property (@(posedge clk) disable iff (srst)
		cycle_start |=> (block_q == $past(block_s)))
		else $error("block input not taken at cycle start");

	res_none_a: assert property (@(posedge clk) disable iff (srst)
		!res_on |=> !(res_curr_start || res_curr_blocked))
		else $error("residual active with none selected");

	ph_gate_a: assert property (@(posedge clk) disable iff (srst)
		(zone_ph_en[0] && !ph_raw && zone_di_mode[1:0] != AFZ_DI_DIRECT) |-> !pickup[0])
		else $error("zone 0 picked up without phase condition");

	res_gate_a: assert property (@(posedge clk) disable iff (srst)
		(zone_res_en[0] && !res_raw && zone_di_mode[1:0] != AFZ_DI_DIRECT) |-> !pickup[0])
		else $error("zone 0 picked up without residual condition");

	di_direct_a: assert property (@(posedge clk) disable iff (srst)
		(zone_en[0] && !mode_off && zone_di_mode[1:0] == AFZ_DI_DIRECT && di_s)
			|-> pickup[0])
		else $error("direct digital input did not pick up zone 0");

	di_qual_a: assert property (@(posedge clk) disable iff (srst)
		(zone_di_mode[1:0] == AFZ_DI_QUAL && !di_s) |-> !pickup[0])
		else $error("qualified zone 0 picked up without digital input");

	cur_excl_a: assert property (@(posedge clk) disable iff (srst)
		!(phase_overcurrent_pickup && ph_curr_blocked) && !(res_curr_start && res_curr_blocked))
		else $error("current start and blocked together");

	thr_load_a: assert property (@(posedge clk) disable iff (srst)
		ph_thr_load |=> (ph_thr_q == $past(ph_thr)))
		else $error("phase threshold not loaded");

	thr_reset_a: assert property (@(posedge clk) disable iff (srst)
		$past(srst) |-> (ph_thr_q == PH_THR_RST && res_thr_q == RES_THR_RST))
		else $error("threshold default lost after reset");

	fault_map_a: assert property (@(posedge clk) disable iff (srst)
		(sensors_cfg != sensors_found) |=> (sensor_fault != '0))
		else $error("sensor fault not flagged");

	fault_last_a: assert property (@(posedge clk) disable iff (srst)
		(sensors_cfg[7:6] != sensors_found[7:6]) |=> sensor_fault[3])
		else $error("last channel sensor fault not flagged");

	fault_clear_a: assert property (@(posedge clk) disable iff (srst)
		(sensors_cfg == sensors_found) |=> (sensor_fault == '0))
		else $error("sensor fault without count mismatch");

	mode_rep_a: assert property (@(posedge clk) disable iff (srst)
		(mode_set <= AFZ_MODE_OFF) |=> (mode_status == $past(mode_set)))
		else $error("mode status does not follow setting");

	mode_clamp_a: assert property (@(posedge clk) disable iff (srst)
		(mode_set > AFZ_MODE_OFF) |=> (mode_status == AFZ_MODE_OFF))
		else $error("unknown mode not reported as off");

	light_copy_a: assert property (@(posedge clk) disable iff (srst)
		pins_settled |-> (chan_light == $past(light_pin, 3)))
		else $error("light status does not follow pins");

	pres_copy_a: assert property (@(posedge clk) disable iff (srst)
		pins_settled |-> (chan_pres == $past(pres_pin, 3)))
		else $error("pressure status does not follow pins");

	di_copy_a: assert property (@(posedge clk) disable iff (srst)
		pins_settled |-> (di_status == $past(di_pin, 3)))
		else $error("digital input status does not follow pin");

	io_copy_a: assert property (@(posedge clk) disable iff (srst)
		pins_settled |-> (io_fault == $past(io_fault_pin, 3)))
		else $error("unit fault status does not follow pin");
endmodule : afz_zone_trip

// file: tb/afz_far_side.sv
// far side: sensor channels, current samples, blocking pin
// assumes the bench posts requests by nonblocking writes at falling edge
`timescale 1ns/1ps
module afz_far_side
	import afz_pkg::*;
(
	input wire logic clk,
	input wire logic [9:0] want,
	input wire logic [CUR_W-1:0] want_cur,
	input wire logic want_smp,
	output logic [CHANS-1:0] light_pin,
	output logic [CHANS-1:0] pres_pin,
	output logic di_pin,
	output logic block_pin,
	output logic sample_valid,
	output logic [CUR_W-1:0] cur
);
	import afz_pkg::*;
	// block is driven on the same falling edge as the sensor and digital input pins
	always @(negedge clk) begin
		{block_pin, di_pin, pres_pin, light_pin} <= want;
		sample_valid <= want_smp;
		cur <= want_cur;
	end
endmodule : afz_far_side

// file: tb/afz_zone_trip_bench.sv
// self-checking bench for the zone trip logic
// assumes the far side model forwards pins one falling edge later
`timescale 1ns/1ps
module afz_zone_trip_bench;
	import afz_pkg::*;
	logic clk = 0, srst = 1, cyc = 0, thl = 0, smp = 0, iof = 0;
	logic [9:0] want = '0;
	logic [CUR_W-1:0] cur_v = '0, cur;
	logic [THR_W-1:0] thr = '0;
	logic [1:0] rsel = '0, ph = '0;
	logic [3:0] need = 4'h1, zen = '0, zph = '0, zres = '0, trip, blkd, sflt, clt, cpr, lp, pp;
	logic [15:0] len = '0, pen = '0;
	logic [7:0] dim = '0, cfg = '0, fnd = '0, e;
	logic [2:0] mset = '0, mst;
	logic phs, phb, rss, rsb, dis, iofo, sv, dp, bp;
	int error_cnt = 0, num_checks = 0, cycles = 0;
	afz_far_side u_far (.clk(clk), .want(want), .want_cur(cur_v), .want_smp(smp),
		.light_pin(lp), .pres_pin(pp), .di_pin(dp), .block_pin(bp), .sample_valid(sv), .cur(cur));
	afz_zone_trip u_dut (.clk(clk), .srst(srst), .cycle_start(cyc), .sample_valid(sv),
		.phase_a_current(ph == 2'h0 ? cur : '0), .phase_b_current(ph == 2'h1 ? cur : '0),
		.phase_c_current(ph == 2'h2 ? cur : '0), .residual_input_first(cur),
		.residual_input_second(cur >> 1), .ph_thr(thr), .res_thr(thr), .ph_thr_load(thl),
		.res_thr_load(thl), .res_sel(rsel), .sample_need(need), .zone_en(zen),
		.zone_ph_en(zph), .zone_res_en(zres), .zone_light_en(len), .zone_pres_en(pen),
		.zone_di_mode(dim), .mode_set(mset), .light_pin(lp), .pres_pin(pp), .di_pin(dp),
		.block_pin(bp), .io_fault_pin(iof), .sensors_cfg(cfg), .sensors_found(fnd),
		.zone_trip(trip), .zone_blocked(blkd), .phase_overcurrent_pickup(phs),
		.ph_curr_blocked(phb), .res_curr_start(rss), .res_curr_blocked(rsb),
		.chan_light(clt), .chan_pres(cpr), .di_status(dis), .sensor_fault(sflt),
		.io_fault(iofo), .mode_status(mst));
	always #2 clk = ~clk;
	function automatic logic [7:0] expect_z(input logic [9:0] w);
		logic [3:0] hit;
		logic b;
		b = w[9] | mset == 3'h1 | mset == 3'h3;
		for (int z = 0; z < 4; z++) begin
			hit[z] = |(w[3:0] & len[z*4+:4]) | |(w[7:4] & pen[z*4+:4]);
			if (dim[z*2+:2] == 2'h1)
				hit[z] = hit[z] | w[8];
			if (dim[z*2+:2] == 2'h2)
				hit[z] = hit[z] & w[8];
			hit[z] = hit[z] & zen[z] & (mset != 3'h4);
		end
		return {hit & {4{b}}, hit & ~{4{b}}};
	endfunction : expect_z
	task automatic check(input string nm, input logic [15:0] seen, input logic [15:0] exp);
		num_checks++;
		if (seen !== exp) begin
			error_cnt++;
			$display("wrong value %s expected %h seen %h", nm, exp, seen);
		end
	endtask : check
	task automatic give_verdict;
		$display("checks %0d mismatches %0d", num_checks, error_cnt);
		if (error_cnt == 0 && num_checks > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask : give_verdict
	task automatic ticks(input int n);
		repeat (n) @(negedge clk);
	endtask : ticks
	task automatic window(input int k, input logic [CUR_W-1:0] hi, input logic [CUR_W-1:0] lo);
		for (int i = 0; i < 5; i++) begin
			cur_v <= (i < k) ? hi : lo;
			smp <= 1;
			ticks(1);
			smp <= 0;
			ticks(1);
		end
		ticks(5);
	endtask : window
	always @(posedge clk) begin
		cycles++;
		if (cycles == 20000) begin
			error_cnt++;
			give_verdict();
		end
	end
	initial begin
		void'($urandom(32'h0336));
		ticks(5);
		srst <= 0;
		ticks(2);
		check("reset", 16'({blkd, trip, mst}), 16'h0000);
		$display("test reset done");
		for (int t = 0; t < 40; t++) begin
			zen <= 4'($urandom);
			len <= 16'($urandom);
			pen <= 16'($urandom);
			dim <= 8'($urandom);
			mset <= 3'($urandom_range(4));
			cfg <= 8'($urandom);
			fnd <= 8'($urandom);
			iof <= 1'($urandom);
			want <= 10'($urandom);
			ticks(7);
			cyc <= 1;
			ticks(1);
			cyc <= 0;
			e = expect_z(want);
			ticks(4);
			check("zone", 16'({blkd, trip}), 16'(e));
			check("chan", 16'({iofo, dis, cpr, clt}), 16'({iof, want[8:0]}));
			for (int c = 0; c < 4; c++)
				check("fault", 16'(sflt[c]), 16'(cfg[c*2+:2] != fnd[c*2+:2]));
			check("mode", 16'(mst), 16'(mset));
			want <= want ^ 10'h200;
			ticks(6);
			check("held block", 16'({blkd, trip}), 16'(e));
		end
		$display("test random zones done");
		zen <= 4'h1;
		len <= 16'h0001;
		pen <= '0;
		dim <= '0;
		mset <= '0;
		zph <= 4'h1;
		want <= 10'h001;
		need <= 4'($urandom_range(1, 5));
		ph <= 2'($urandom_range(2));
		ticks(7);
		cyc <= 1;
		ticks(1);
		cyc <= 0;
		window(need - 1, 16'h0079, 16'h0078);
		check("ph short", 16'({phs, trip}), 16'h0000);
		window(need, 16'h0079, 16'h0078);
		check("ph pick", 16'({phs, trip}), 16'h0011);
		thr <= 13'h00C8;
		thl <= 1;
		ticks(1);
		thl <= 0;
		window(need, 16'h0096, 16'h0078);
		check("new thr", 16'({phs, trip}), 16'h0000);
		zph <= 4'h0;
		zres <= 4'h1;
		window(5, 16'h7FFF, 16'h7FFF);
		check("res none", 16'({rss, trip}), 16'h0000);
		rsel <= 2'h1;
		window(5, 16'h7FFF, 16'h7FFF);
		check("res first", 16'({rss, trip}), 16'h0011);
		mset <= 3'h1;
		rsel <= 2'h2;
		window(5, 16'h7FFF, 16'h7FFF);
		check("cur blocked", 16'({phb, phs, rsb, rss, blkd, trip}), 16'h0A10);
		mset <= 3'h0;
		window(5, 16'h0100, 16'h0100);
		check("res second", 16'({rss, trip}), 16'h0000);
		rsel <= 2'h3;
		window(5, 16'h7FFF, 16'h7FFF);
		check("res three", 16'({rsb, rss, trip}), 16'h0000);
		mset <= 3'($urandom_range(7, 5));
		ticks(3);
		check("mode clamp", 16'({mst, blkd, trip}), 16'h0400);
		$display("test currents done");
		give_verdict();
	end
endmodule : afz_zone_trip_bench
